// *** design/crl_pkg.sv ***
/*
 * package for the comparator reference ladder control block:
 * register offsets, field positions, reset values.
 * assumes a 32-bit apb bus with word-aligned registers.
 */
package crl_pkg;

    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [7:0] CRL_OFF_LADDER_CTRL = 8'h00;
    localparam logic [7:0] CRL_OFF_CMP_CTRL    = 8'h04;

    // ==========================================================
    // reference_ladder_control fields
    localparam int CRL_POS_ENABLE = 7;
    localparam int CRL_POS_UNUSED = 6;
    localparam int CRL_POS_RANGE  = 5;
    localparam int CRL_POS_SOURCE = 4;
    localparam int CRL_POS_LEVEL  = 0;
    localparam int CRL_LEVEL_W    = 4;

    // writable bits: all but bit 6
    localparam logic [7:0] CRL_LADDER_WMASK = 8'hbf;
    localparam logic [7:0] CRL_LADDER_RESET = 8'h00;

    // ==========================================================
    // comparator_control fields
    localparam int CRL_POS_CMP_EN  = 0;
    localparam int CRL_CMP_EN_W    = 3;
    localparam int CRL_POS_CMP_OUT = 5;
    localparam int CRL_CMP_OUT_W   = 3;
    localparam logic [2:0] CRL_CMP_EN_RESET = 3'h0;

endpackage

// *** design/crl_sync.sv ***
/*
 * two-flop synchroniser, one generate copy per bit.
 * assumes the input is asynchronous to pclk.
 */
`timescale 1ns/1ps
module crl_sync #(
    parameter int W = 3
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    // ==========================================================
    // per-bit double flop
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                meta[i] <= 1'b0;
                q[i]    <= 1'b0;
            end else begin
                meta[i] <= d[i];
                q[i]    <= meta[i];
            end
        end
    end
endmodule // crl_sync

// *** design/crl_ladder_ctrl.sv ***
/*
 * apb register bank driving the comparator reference ladder controls,
 * plus the comparator control register it sits beside.
 * assumes apb master keeps psel/penable protocol; comparator outputs
 * arrive asynchronously from the analog block.
 */
// Contract
// - bit 7 powers ladder on or off
// - bit 5 picks low or high range
// - bit 4 picks external or analog supply
// - bits 3-0 accept any level 0-15
// - bit 6 reads zero, ignores writes
// - reset clears enable, range, level
// - sleep wake leaves register unchanged
`timescale 1ns/1ps
module crl_ladder_ctrl
    import crl_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [2:0]  cmp_out_async,
    output logic             ladder_power_enable,
    output logic             range_select,
    output logic             supply_source_select,
    output logic      [3:0]  level_code,
    output logic      [2:0]  cmp_enable
);

    // ==========================================================
    // bus decode
    logic        access;
    logic        wr;
    logic        hit_ladder;
    logic        hit_cmp;
    logic [7:0]  ladder_reg;
    logic [7:0]  next_ladder;
    logic [2:0]  cmp_out;

    assign access     = psel && penable;
    assign wr         = access && pwrite && pstrb[0];
    assign hit_ladder = (paddr == CRL_OFF_LADDER_CTRL);
    assign hit_cmp    = (paddr == CRL_OFF_CMP_CTRL);
    assign pready     = 1'b1;
    assign pslverr    = access && !hit_ladder && !hit_cmp;

    // ==========================================================
    // comparator outputs into pclk domain
    crl_sync #(.W(CRL_CMP_OUT_W)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (cmp_out_async),
        .q       (cmp_out)
    );

    // ==========================================================
    // ladder control register
    // mask out bit 6
    assign next_ladder = pwdata[7:0] & CRL_LADDER_WMASK;

    // only reset or a write changes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ladder_reg <= CRL_LADDER_RESET;
        end else if (wr && hit_ladder) begin
            ladder_reg <= next_ladder;
        end
    end

    assign ladder_power_enable  = ladder_reg[CRL_POS_ENABLE];
    assign range_select         = ladder_reg[CRL_POS_RANGE];
    assign supply_source_select = ladder_reg[CRL_POS_SOURCE];
    assign level_code = ladder_reg[CRL_POS_LEVEL +: CRL_LEVEL_W];

    // ==========================================================
    // comparator control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_enable <= CRL_CMP_EN_RESET;
        end else if (wr && hit_cmp) begin
            cmp_enable <= pwdata[CRL_POS_CMP_EN +: CRL_CMP_EN_W];
        end
    end

    // ==========================================================
    // read data, registered during setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == CRL_OFF_LADDER_CTRL) begin
                prdata <= {24'h00_0000, ladder_reg};
            end else if (paddr == CRL_OFF_CMP_CTRL) begin
                prdata <= {24'h00_0000, cmp_out, 2'h0, cmp_enable};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ==========================================================
    // checks
    // write visible next cycle
    a_write_update: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr && hit_ladder |=>
            ladder_reg == ($past(pwdata[7:0]) & CRL_LADDER_WMASK))
        else $error("ladder write not applied");

    a_bit6_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        ladder_reg[CRL_POS_UNUSED] == 1'b0)
        else $error("unimplemented bit set");

    a_hold_value: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(wr && hit_ladder) |=> $stable(ladder_reg))
        else $error("ladder changed without write");

    a_enable_follow: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr && hit_ladder |=>
            ladder_power_enable == $past(pwdata[CRL_POS_ENABLE]))
        else $error("enable mismatch");

    a_range_follow: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr && hit_ladder |=>
            range_select == $past(pwdata[CRL_POS_RANGE]))
        else $error("range mismatch");

    a_source_follow: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr && hit_ladder |=>
            supply_source_select == $past(pwdata[CRL_POS_SOURCE]))
        else $error("source mismatch");

    a_level_follow: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr && hit_ladder |=>
            level_code == $past(pwdata[CRL_POS_LEVEL +: CRL_LEVEL_W]))
        else $error("level mismatch");

    a_reset_clear: assert property (
        @(posedge pclk)
        $rose(presetn) |-> ladder_reg == CRL_LADDER_RESET)
        else $error("ladder not cleared by reset");

    // read shows zero in bit 6
    a_read_bit6: assert property (
        @(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && hit_ladder |=>
            prdata[CRL_POS_UNUSED] == 1'b0)
        else $error("bit 6 read nonzero");

    // ==========================================================
    // apb phase sequences for the checks
    sequence s_ladder_write;
        (psel && !penable && pwrite && hit_ladder)
        ##1 (access && pwrite && pstrb[0] && hit_ladder);
    endsequence

    sequence s_cmp_write;
        (psel && !penable && pwrite && hit_cmp)
        ##1 (access && pwrite && pstrb[0] && hit_cmp);
    endsequence

    sequence s_stray_write;
        (psel && !penable && pwrite && !hit_ladder && !hit_cmp)
        ##1 (access && pwrite && !hit_ladder && !hit_cmp);
    endsequence

    sequence s_ladder_read;
        (psel && !penable && !pwrite && hit_ladder)
        ##1 (access && !pwrite && hit_ladder);
    endsequence

    sequence s_cmp_read;
        (psel && !penable && !pwrite && hit_cmp)
        ##1 (access && !pwrite && hit_cmp);
    endsequence

    // ==========================================================
    // bus transfer checks
    // ladder write completes cleanly
    a_write_ok: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_ladder_write |-> pready && !pslverr)
        else $error("ladder write not completed");

    a_ready_high: assert property (
        @(posedge pclk) disable iff (!presetn)
        access |-> pready)
        else $error("access phase without ready");

    a_err_unmapped: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_stray_write |-> pslverr)
        else $error("unmapped write not flagged");

    a_unmapped_ignore: assert property (
        @(posedge pclk) disable iff (!presetn)
        access && pwrite && pslverr |=>
            $stable(ladder_reg) && $stable(cmp_enable))
        else $error("unmapped write changed a register");

    a_strb_ignore: assert property (
        @(posedge pclk) disable iff (!presetn)
        access && pwrite && !pstrb[0] |=>
            $stable(ladder_reg) && $stable(cmp_enable))
        else $error("write without low strobe applied");

    // ==========================================================
    // read path checks
    // ladder read returns register
    a_ladder_read: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_ladder_read |->
            prdata == {24'h00_0000, $past(ladder_reg)})
        else $error("ladder read data wrong");

    a_cmp_read: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_cmp_read |->
            prdata == {24'h00_0000, $past(cmp_out), 2'h0,
                       $past(cmp_enable)})
        else $error("comparator read data wrong");

    a_unmapped_read: assert property (
        @(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && !hit_ladder && !hit_cmp |=>
            prdata == 32'h0000_0000)
        else $error("unmapped read nonzero");

    a_upper_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite |=>
            prdata[31:8] == 24'h00_0000)
        else $error("upper read bytes nonzero");

    a_prdata_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data changed outside setup");

    // ==========================================================
    // comparator and output checks
    // comparator enables follow write
    a_cmp_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_cmp_write |=>
            cmp_enable == $past(pwdata[CRL_POS_CMP_EN +: CRL_CMP_EN_W]))
        else $error("comparator enable write not applied");

    a_cmp_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(wr && hit_cmp) |=> $stable(cmp_enable))
        else $error("comparator enables changed without write");

    a_cmp_reset: assert property (
        @(posedge pclk)
        $rose(presetn) |-> cmp_enable == CRL_CMP_EN_RESET)
        else $error("comparator enables not cleared by reset");

    a_reset_outputs: assert property (
        @(posedge pclk)
        $rose(presetn) |->
            ladder_power_enable == CRL_LADDER_RESET[CRL_POS_ENABLE] &&
            range_select == CRL_LADDER_RESET[CRL_POS_RANGE] &&
            level_code ==
                CRL_LADDER_RESET[CRL_POS_LEVEL +: CRL_LEVEL_W])
        else $error("ladder outputs not cleared by reset");

    a_outputs_static: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(wr && hit_ladder) |=>
            $stable({ladder_power_enable, range_select,
                     supply_source_select, level_code}))
        else $error("ladder outputs changed without write");

endmodule // crl_ladder_ctrl

// *** sim/tb_top.sv ***
/*
 * self-checking bench for the ladder control register bank over apb.
 * assumes ladder at 0x00 and comparator control at 0x04; waits on pready.
 */
`timescale 1ns/1ps
module tb_top
    import crl_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'h0;
    logic [2:0]  cmp_out_async = 3'h5;
    logic [31:0] prdata;
    logic        pready, pslverr, power, rng, src;
    logic [3:0]  level_code;
    logic [2:0]  cmp_enable;
    logic [7:0]  outs, v;
    int          failures = 0;
    int          num_checks = 0;
    assign outs = {power, 1'b0, rng, src, level_code};
    always #12.5 pclk = ~pclk;
    crl_ladder_ctrl crl_ladder_ctrl_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmp_out_async(cmp_out_async),
        .ladder_power_enable(power), .range_select(rng),
        .supply_source_select(src), .level_code(level_code),
        .cmp_enable(cmp_enable));
    // ==========================================================
    // checking and apb tasks
    task automatic chk(input string n, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            failures++;
        end
    endtask
    task automatic apb(input logic [7:0] a, input logic w,
        input logic [31:0] d, input logic [3:0] s,
        output logic [31:0] r, output logic err);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        pstrb <= s;
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s, input logic e);
        logic [31:0] r;
        logic x;
        apb(a, 1'b1, d, s, r, x);
        chk("pslverr", {31'h0, e}, {31'h0, x});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        logic x;
        apb(a, 1'b0, 32'h0, 4'h0, r, x);
        chk("prdata", e, r);
    endtask
    task automatic ck_out(input logic [7:0] e);
        chk("ladder outputs", {24'h0, e}, {24'h0, outs});
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ==========================================================
    // test sequence
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        ck_out(8'h00);
        rd(CRL_OFF_LADDER_CTRL, 32'h0);
        $display("reset test done");
        for (int i = 0; i < 16; i++) begin
            v = {i[0], 1'b1, ~i[0], i[1], i[3:0]};
            wr(CRL_OFF_LADDER_CTRL, {24'ha5a5a5, v}, 4'hf, 1'b0);
            ck_out(v & 8'hbf);
            rd(CRL_OFF_LADDER_CTRL, {24'h0, v & 8'hbf});
        end
        $display("field test done");
        wr(CRL_OFF_LADDER_CTRL, 32'h0, 4'he, 1'b0);
        wr(8'h08, 32'h0, 4'hf, 1'b1);
        repeat (40) @(posedge pclk);
        ck_out(8'h9f);
        rd(8'h08, 32'h0);
        $display("refusal and hold test done");
        wr(CRL_OFF_LADDER_CTRL, 32'h1f, 4'h1, 1'b0);
        repeat (40) @(posedge pclk);
        ck_out(8'h1f);
        rd(CRL_OFF_LADDER_CTRL, 32'h1f);
        $display("sleep hold test done");
        wr(CRL_OFF_CMP_CTRL, 32'hff, 4'h1, 1'b0);
        chk("cmp_enable", 32'h7, {29'h0, cmp_enable});
        rd(CRL_OFF_CMP_CTRL, 32'ha7);
        cmp_out_async <= 3'h2;
        repeat (3) @(posedge pclk);
        rd(CRL_OFF_CMP_CTRL, 32'h47);
        $display("comparator test done");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        ck_out(8'h00);
        chk("cmp_enable", 32'h0, {29'h0, cmp_enable});
        rd(CRL_OFF_LADDER_CTRL, 32'h0);
        $display("mid-run reset test done");
        summarize();
    end
    initial begin
        repeat (5000) @(posedge pclk);
        failures++;
        summarize();
    end
endmodule // tb_top
